// file: ocd_map.svh
// Constant map for the clock configuration decoder
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH
`define OCD_SHIFT_BASE        3'h1
`define OCD_AUX_REFERENCE_CLOCK        2'h0
`define OCD_AUX_RSVD          2'h1
`define OCD_AUX_PLLCLK        2'h2
`define OCD_AUX_LOCK          2'h3
`define OCD_DIV_4             2'h0
`define OCD_DIV_2             2'h1
`define OCD_DIV_1             2'h2
`define OCD_DIV_RSVD          2'h3
`define OCD_FN_DIS_CLK        3'h0
`define OCD_FN_DIS_AUX        3'h1
`define OCD_FN_DIS_BOTH       3'h2
`define OCD_FN_RMOD           3'h3
`define OCD_FN_FORCE          3'h7
`define OCD_STYLE_PUSHPULL    1'h0
`define OCD_STYLE_OPENDRAIN   1'h1
`define OCD_FRAC_BITS         20
`define OCD_RELOCK_CYCLES     8'h10
`endif

// file: ocd_pkg.sv
// Types for the clock configuration decoder
package ocd_pkg;
  // One modal configuration set
  typedef struct packed
  {
    logic [31:0] user_ratio;           // 12.20 unsigned ratio
    logic [1:0]  ratio_shift_select;   // Shift code
    logic [1:0]  aux_source_select;    // Aux source code
  } ocd_modal_type;

  // Global configuration
  typedef struct packed
  {
    logic       lock_pin_style;        // 0 push-pull, 1 open drain
    logic [1:0] ref_divider_select;    // Reference divider code
    logic       run_through_unlock;    // Keep clocks during unlock
    logic [2:0] third_pin_function;    // Function pin mapping
  } ocd_global_type;

  // Aux pin two-signal carrier
  typedef struct packed
  {
    logic o;                           // Output level
    logic oe;                          // Output enable
  } ocd_pin_type;

  // Relock sequencer state
  typedef enum logic [0:0]
  {
    OCD_ST_LOCKED  = 1'b0,
    OCD_ST_RELOCK  = 1'b1
  } ocd_state_type;
endpackage

// file: ocd_decode.sv
// Decoder of one-time-programmed clock synthesizer configuration
`timescale 1ns/1ns
`include "ocd_map.svh"

module ocd_decode
#(
  parameter int RELOCK_W = 8                       // Relock counter width
)
(
  input  wire logic                   clk_i,          // Reference domain clock
  input  wire logic                   resetn_i,       // Async reset, active low
  input  wire ocd_pkg::ocd_modal_type modal_set0_i,   // Programmed set 0
  input  wire ocd_pkg::ocd_modal_type modal_set1_i,   // Programmed set 1
  input  wire ocd_pkg::ocd_modal_type modal_set2_i,   // Programmed set 2
  input  wire ocd_pkg::ocd_modal_type modal_set3_i,   // Programmed set 3
  input  wire ocd_pkg::ocd_global_type global_cfg_i,  // Programmed globals
  input  wire logic [1:0]             set_select_i,   // Set-select pins
  input  wire logic                   function_pin_i, // Third mode pin
  input  wire logic                   pll_locked_i,   // Analog PLL lock level
  input  wire logic                   pll_clk_i,      // PLL clock as a level
  input  wire logic                   ref_clk_lvl_i,  // Reference clock level
  output logic [31:0]                 eff_ratio_o,    // Effective 12.20 ratio
  output logic [2:0]                  ref_div_o,      // Reference divide factor
  output logic                        ref_div_bad_o,  // Reserved divider code
  output logic                        force_unlock_o, // Relock request to PLL
  output logic                        clk_out_o,      // PLL clock pin level
  output logic                        clk_out_oe_o,   // PLL clock pin enable
  output logic                        aux_out_o,      // Aux pin level
  output logic                        aux_out_oe_o,   // Aux pin enable
  output logic                        cfg_bad_o       // Reserved code in use
);
  import ocd_pkg::*;

  // Parameter check at elaboration, counter must hold the relock count
  if (RELOCK_W < 5)
  begin : g_relock_w_bad
    $error("RELOCK_W too small for relock count");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sel_s1_r;      // First stage, set select
  logic [1:0] sel_s2_r;      // Second stage, set select
  logic [1:0] sel_q_r;       // Previous synced select
  logic       fn_s1_r;       // First stage, function pin
  logic       fn_s2_r;       // Second stage, function pin
  logic       lk_s1_r;       // First stage, lock
  logic       lk_s2_r;       // Second stage, lock
  logic       pc_s1_r;       // First stage, pll clock
  logic       pc_s2_r;       // Second stage, pll clock
  logic       rc_s1_r;       // First stage, ref clock
  logic       rc_s2_r;       // Second stage, ref clock

  // Two flops on every outside pin input
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sel_s1_r <= 2'h0;
      sel_s2_r <= 2'h0;
      sel_q_r  <= 2'h0;
      fn_s1_r  <= 1'h0;
      fn_s2_r  <= 1'h0;
      lk_s1_r  <= 1'h0;
      lk_s2_r  <= 1'h0;
      pc_s1_r  <= 1'h0;
      pc_s2_r  <= 1'h0;
      rc_s1_r  <= 1'h0;
      rc_s2_r  <= 1'h0;
    end
    else
    begin
      sel_s1_r <= set_select_i;
      sel_s2_r <= sel_s1_r;
      sel_q_r  <= sel_s2_r;
      fn_s1_r  <= function_pin_i;
      fn_s2_r  <= fn_s1_r;
      lk_s1_r  <= pll_locked_i;
      lk_s2_r  <= lk_s1_r;
      pc_s1_r  <= pll_clk_i;
      pc_s2_r  <= pc_s1_r;
      rc_s1_r  <= ref_clk_lvl_i;
      rc_s2_r  <= rc_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Shift ratio right by code plus one
  function automatic logic [31:0] ocd_shift(input logic [31:0] r, input logic [1:0] c);
    logic [2:0] n;
    n = {1'b0, c} + `OCD_SHIFT_BASE;
    return r >> n;
  endfunction

  // Divider factor from code, zero when reserved
  function automatic logic [2:0] ocd_div(input logic [1:0] c);
    logic [2:0] f;
    f = 3'h0;
    if (c == `OCD_DIV_4)
      f = 3'h4;
    else if (c == `OCD_DIV_2)
      f = 3'h2;
    else if (c == `OCD_DIV_1)
      f = 3'h1;
    return f;
  endfunction

  // ----------------------------------------------------------------
  // Modal set selection and decode
  // ----------------------------------------------------------------
  ocd_modal_type  act_set;   // Active modal set
  ocd_global_type gcfg;      // Globals alias
  logic           fn_rsvd;   // Reserved function code
  logic           rmod_en;   // Shift enable
  logic           force_pll; // Aux forced to pll clock
  logic           dis_clk;   // Clock pin disabled
  logic           dis_aux;   // Aux pin disabled
  logic [1:0]     aux_src;   // Effective aux source
  logic           unlocked;  // Synced unlock level

  assign gcfg     = global_cfg_i;
  assign unlocked = ~lk_s2_r;

  // Choose one of four stored sets
  always_comb
  begin
    case (sel_s2_r)
      2'h0:    act_set = modal_set0_i;
      2'h1:    act_set = modal_set1_i;
      2'h2:    act_set = modal_set2_i;
      default: act_set = modal_set3_i;
    endcase
  end

  // Function pin mapping
  always_comb
  begin
    fn_rsvd   = (gcfg.third_pin_function > `OCD_FN_RMOD) &&
                (gcfg.third_pin_function != `OCD_FN_FORCE);
    rmod_en   = fn_s2_r && (gcfg.third_pin_function == `OCD_FN_RMOD);
    force_pll = fn_s2_r && (gcfg.third_pin_function == `OCD_FN_FORCE);
    dis_clk   = fn_s2_r && ((gcfg.third_pin_function == `OCD_FN_DIS_CLK) ||
                (gcfg.third_pin_function == `OCD_FN_DIS_BOTH));
    dis_aux   = fn_s2_r && ((gcfg.third_pin_function == `OCD_FN_DIS_AUX) ||
                (gcfg.third_pin_function == `OCD_FN_DIS_BOTH));
    aux_src   = force_pll ? `OCD_AUX_PLLCLK : act_set.aux_source_select;
  end

  // ----------------------------------------------------------------
  // Ratio and divider registers
  // ----------------------------------------------------------------
  // Effective ratio, unsigned 12.20
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      eff_ratio_o <= 32'h0;
    else if (rmod_en)
      eff_ratio_o <= ocd_shift(act_set.user_ratio, act_set.ratio_shift_select);
    else
      eff_ratio_o <= act_set.user_ratio;
  end

  // Reference divider factor
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_div_o     <= 3'h0;
      ref_div_bad_o <= 1'h0;
    end
    else
    begin
      ref_div_o     <= ocd_div(gcfg.ref_divider_select);
      ref_div_bad_o <= (gcfg.ref_divider_select == `OCD_DIV_RSVD);
    end
  end

  // Flag any reserved code in use
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cfg_bad_o <= 1'h0;
    else
      cfg_bad_o <= fn_rsvd || (act_set.aux_source_select == `OCD_AUX_RSVD) ||
                   (gcfg.ref_divider_select == `OCD_DIV_RSVD);
  end

  // ----------------------------------------------------------------
  // Relock sequencer on set change
  // ----------------------------------------------------------------
  ocd_state_type       st_r;     // Relock state
  logic [RELOCK_W-1:0] cnt_r;    // Relock counter

  // Set change drops lock for a fixed time
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r  <= OCD_ST_LOCKED;
      cnt_r <= '0;
    end
    else if (sel_s2_r != sel_q_r)
    begin
      st_r  <= OCD_ST_RELOCK;
      cnt_r <= RELOCK_W'(`OCD_RELOCK_CYCLES);
    end
    else
    begin
      case (st_r)
        OCD_ST_RELOCK:
        begin
          if (cnt_r == RELOCK_W'(1))
            st_r <= OCD_ST_LOCKED;
          cnt_r <= cnt_r - RELOCK_W'(1);
        end
        default:
          cnt_r <= '0;
      endcase
    end
  end

  // Relock request output
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      force_unlock_o <= 1'h0;
    else
      force_unlock_o <= (sel_s2_r != sel_q_r) || (st_r == OCD_ST_RELOCK);
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  logic gate_clk;   // Clocks held low for unlock
  assign gate_clk = unlocked && !gcfg.run_through_unlock;

  // PLL clock pin
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clk_out_o    <= 1'h0;
      clk_out_oe_o <= 1'h0;
    end
    else
    begin
      clk_out_o    <= pc_s2_r && !gate_clk;
      clk_out_oe_o <= !dis_clk;
    end
  end

  // Aux pin source mux and driver style
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aux_out_o    <= 1'h0;
      aux_out_oe_o <= 1'h0;
    end
    else if (aux_src == `OCD_AUX_LOCK)
    begin
      if (gcfg.lock_pin_style == `OCD_STYLE_PUSHPULL)
      begin
        aux_out_o    <= unlocked;
        aux_out_oe_o <= !dis_aux;
      end
      else
      begin
        aux_out_o    <= 1'h0;
        aux_out_oe_o <= unlocked && !dis_aux;
      end
    end
    else
    begin
      // Clock source: style ignored
      aux_out_oe_o <= !dis_aux;
      if (aux_src == `OCD_AUX_REFERENCE_CLOCK)
        aux_out_o <= rc_s2_r;
      else if (aux_src == `OCD_AUX_PLLCLK)
        aux_out_o <= pc_s2_r && !gate_clk;
      else
        aux_out_o <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ratio_plain: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !rmod_en |=> eff_ratio_o == $past(act_set.user_ratio))
    else $error("ratio changed without enable");
  a_ratio_shift: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rmod_en && act_set.ratio_shift_select == 2'h3 |=> eff_ratio_o == ($past(act_set.user_ratio) >> 4))
    else $error("shift by four wrong");
  a_div_four: assert property (@(posedge clk_i) disable iff (!resetn_i)
    gcfg.ref_divider_select == 2'h0 |=> ref_div_o == 3'h4)
    else $error("divider code 00 wrong");
  a_relock_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sel_s2_r != sel_q_r |=> force_unlock_o [*8])
    else $error("relock too short");
  a_clk_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    unlocked && !gcfg.run_through_unlock |=> !clk_out_o)
    else $error("clock not held low");
  a_clk_disable: assert property (@(posedge clk_i) disable iff (!resetn_i)
    fn_s2_r && gcfg.third_pin_function == 3'h0 |=> !clk_out_oe_o)
    else $error("clock pin not disabled");
  a_lock_pp: assert property (@(posedge clk_i) disable iff (!resetn_i)
    aux_src == 2'h3 && !gcfg.lock_pin_style && !dis_aux |=> aux_out_oe_o && aux_out_o == $past(unlocked))
    else $error("push-pull lock wrong");
  a_lock_od: assert property (@(posedge clk_i) disable iff (!resetn_i)
    aux_src == 2'h3 && gcfg.lock_pin_style |=> !aux_out_o && (!aux_out_oe_o || $past(unlocked)))
    else $error("open drain lock wrong");
  a_force_src: assert property (@(posedge clk_i) disable iff (!resetn_i)
    force_pll |=> aux_out_oe_o && aux_out_o == $past(pc_s2_r && !gate_clk))
    else $error("force not applied");
  c_relock: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(force_unlock_o));
  c_rmod: cover property (@(posedge clk_i) disable iff (!resetn_i) rmod_en);
  c_force: cover property (@(posedge clk_i) disable iff (!resetn_i) force_pll);
endmodule

// file: ocd_board_model.sv
// Board-side model: reference clock, PLL clock and lock levels
`timescale 1ns/1ns
module ocd_board_model
(
  input  wire logic clk_i,          // Bench clock
  input  wire logic resetn_i,       // Async reset, active low
  input  wire logic force_unlock_i, // Relock request from decoder
  input  wire logic hold_unlock_i,  // Bench-commanded lock loss
  output logic      ref_clk_lvl_o,  // Reference clock level
  output logic      pll_clk_o,      // PLL clock level
  output logic      pll_locked_o    // Lock status, high = locked
);
  // ----------------------------------------
  // Clock levels and lock status
  // ----------------------------------------
  logic [1:0] phase_r; // Free-running phase counter

  // Reference toggles every cycle, PLL clock every two
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_r      <= 2'h0;
      pll_locked_o <= 1'h0;
    end
    else
    begin
      phase_r      <= phase_r + 2'h1;
      pll_locked_o <= !(force_unlock_i || hold_unlock_i);
    end
  end

  assign ref_clk_lvl_o = phase_r[0];
  assign pll_clk_o     = phase_r[1];
endmodule

// file: ocd_decode_tb.sv
// Self-checking testbench for the clock configuration decoder
`timescale 1ns/1ns
module ocd_decode_tb;
  import ocd_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic           clk_i, resetn_i, fn_pin, hold_unl, ref_lvl, pll_lvl, locked;
  logic [1:0]     sel;      // Set-select pins
  ocd_modal_type  ms [4];   // Programmed sets
  ocd_global_type gc;       // Programmed globals
  logic [31:0]    eff;      // Effective ratio
  logic [2:0]     div;      // Divide factor
  logic           div_bad, f_unl, co, co_oe, ao, ao_oe, bad;
  logic [2:0]     ref_h, pll_h; // Level history, [2] is two edges old
  int             error_cnt, check_count;

  ocd_decode i_ocd_decode (.clk_i(clk_i), .resetn_i(resetn_i), .modal_set0_i(ms[0]),
    .modal_set1_i(ms[1]), .modal_set2_i(ms[2]), .modal_set3_i(ms[3]), .global_cfg_i(gc),
    .set_select_i(sel), .function_pin_i(fn_pin), .pll_locked_i(locked), .pll_clk_i(pll_lvl),
    .ref_clk_lvl_i(ref_lvl), .eff_ratio_o(eff), .ref_div_o(div), .ref_div_bad_o(div_bad),
    .force_unlock_o(f_unl), .clk_out_o(co), .clk_out_oe_o(co_oe), .aux_out_o(ao),
    .aux_out_oe_o(ao_oe), .cfg_bad_o(bad));
  ocd_board_model i_ocd_board_model (.clk_i(clk_i), .resetn_i(resetn_i),
    .force_unlock_i(f_unl), .hold_unlock_i(hold_unl), .ref_clk_lvl_o(ref_lvl),
    .pll_clk_o(pll_lvl), .pll_locked_o(locked));

  // Clock at 25 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Level history for routed clock checks
  always @(posedge clk_i)
  begin
    ref_h <= {ref_h[1:0], ref_lvl};
    pll_h <= {pll_h[1:0], pll_lvl};
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    check_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask

  // Wait n edges, then settle
  task wt(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask

  task report_and_stop;
    $display("Counts: %0d checks, %0d mismatches", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Each set selects its own ratio and triggers a relock
  task t_select;
    for (int i = 1; i < 5; i++)
    begin
      @(posedge clk_i) sel <= 2'(i);
      wt(4);
      chk(eff, ms[i % 4].user_ratio, "ratio of set");
      chk(f_unl, 1, "relock high");
      wt(14);
      chk(f_unl, 1, "relock held");
      wt(3);
      chk(f_unl, 0, "relock end");
      wt(4);
    end
    $display("t_select done");
  endtask

  // Shift codes with pin high, then reserved codes
  task t_shift;
    @(posedge clk_i) fn_pin <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk_i) ms[0].ratio_shift_select <= 2'(c);
      wt(5);
      chk(eff, ms[0].user_ratio >> (c + 1), "shifted ratio");
    end
    for (int f = 4; f < 7; f++)
    begin
      @(posedge clk_i) gc.third_pin_function <= 3'(f);
      wt(3);
      chk(eff, ms[0].user_ratio, "reserved code ratio");
      chk(bad, 1, "reserved flag");
    end
    $display("t_shift done");
  endtask

  // Divider codes
  task t_div;
    for (int d = 0; d < 4; d++)
    begin
      @(posedge clk_i) gc.ref_divider_select <= 2'(d);
      wt(3);
      chk(div, d == 0 ? 4 : d == 1 ? 2 : d == 2 ? 1 : 0, "divide factor");
      chk(div_bad, d == 3, "divider flag");
    end
    // Back to a supported divider so later reserved-flag checks stay clean
    @(posedge clk_i) gc.ref_divider_select <= 2'h2;
    wt(3);
    chk(div_bad, 0, "divider flag cleared");
    $display("t_div done");
  endtask

  // Output disable codes, pin low enables and high disables
  task t_disable;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk_i);
      gc.third_pin_function <= 3'(k / 2);
      fn_pin                <= k[0];
      wt(5);
      chk(co_oe, !(k[0] && k / 2 != 1), "clock enable");
      chk(ao_oe, !(k[0] && k / 2 != 0), "aux enable");
    end
    $display("t_disable done");
  endtask

  // Lock indicator styles and clock gating on unlock
  task t_lock;
    @(posedge clk_i);
    fn_pin                <= 1'b0;
    ms[0].aux_source_select <= 2'h3;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_i);
      gc.lock_pin_style <= k[1];
      hold_unl          <= k[0];
      wt(6);
      chk(ao, k[1] ? 0 : k[0], "lock level");
      chk(ao_oe, k[1] ? k[0] : 1, "lock drive");
      if (k[0])
        chk(co, 0, "clock held low");
    end
    @(posedge clk_i) gc.run_through_unlock <= 1'b1;
    wt(3);
    repeat (4)
    begin
      chk(co, pll_h[2], "run-through clock");
      wt(1);
    end
    @(posedge clk_i);
    hold_unl              <= 1'b0;
    gc.run_through_unlock <= 1'b0;
    $display("t_lock done");
  endtask

  // Aux routing, forced source and reserved source
  task t_route;
    logic [1:0] src [4];
    logic [1:0] kind [4];
    src  = '{2'h0, 2'h2, 2'h0, 2'h1};
    kind = '{2'h0, 2'h1, 2'h1, 2'h2};
    @(posedge clk_i) gc.third_pin_function <= 3'h7;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_i);
      ms[0].aux_source_select <= src[k];
      fn_pin                  <= (k == 2);
      wt(6);
      repeat (4)
      begin
        chk(ao, kind[k] == 0 ? ref_h[2] : kind[k] == 1 ? pll_h[2] : 0, "aux level");
        chk(ao_oe, 1, "aux drive, style ignored");
        chk(co, pll_h[2], "locked clock");
        wt(1);
      end
      chk(bad, k == 3, "aux reserved flag");
    end
    $display("t_route done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    resetn_i    = 1'b0;
    sel         = 2'h0;
    fn_pin      = 1'b0;
    hold_unl    = 1'b0;
    error_cnt   = 0;
    check_count = 0;
    ms[0] = '{32'h0013a92a, 2'h0, 2'h0};
    ms[1] = '{32'h10000000, 2'h1, 2'h2};
    ms[2] = '{32'h87654321, 2'h2, 2'h3};
    ms[3] = '{32'hfedcba98, 2'h3, 2'h0};
    gc    = '{1'h0, 2'h2, 1'h0, 3'h3};
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    wt(4);
    t_select;
    t_shift;
    t_div;
    t_disable;
    t_lock;
    t_route;
    report_and_stop;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    report_and_stop;
  end
endmodule
